// ==== hdl/svwt_top.sv ====
// Supervisor timing: power-on reset, watchdog, write cycle and bus filtering
module svwt_top
	import svwt_pkg::*;
#(
	parameter longint unsigned CYC_MS = CYC_PER_MS
)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire svwt_pkg::svwt_cfg_t cfg,
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	input  wire logic             wdt_restart,
	input  wire logic             write_stop,
	input  wire logic             sel_match,
	output logic                  reset_n,
	output logic                  watchdog_alarm_n,
	output logic                  write_busy,
	output logic                  bus_active,
	output svwt_pkg::svwt_bus_t   bus_filt
);

	// ------------------------------------------------------------
	// Input filtering
	// ------------------------------------------------------------
	svwt_bus_t filt;

	// One filter per bus line
	svwt_glitch_filter u_scl_flt
	(
		.clk    (clk),
		.arst_n (arst_n),
		.din    (scl_in),
		.dout   (filt.scl)
	);

	svwt_glitch_filter u_sda_flt
	(
		.clk    (clk),
		.arst_n (arst_n),
		.din    (sda_in),
		.dout   (filt.sda)
	);

	assign bus_filt = filt;

	// ------------------------------------------------------------
	// Bus start and stop detection and standby tracking
	// ------------------------------------------------------------
	svwt_bus_t   prev_r;
	logic        act_r;
	logic        act_nxt;
	logic [3:0]  sclk_r;
	logic [3:0]  sclk_nxt;
	logic        start_ev;
	logic        stop_ev;
	logic        scl_rise;

	assign start_ev = prev_r.sda & ~filt.sda & filt.scl & prev_r.scl;
	assign stop_ev  = ~prev_r.sda & filt.sda & filt.scl & prev_r.scl;
	assign scl_rise = ~prev_r.scl & filt.scl;

	// Active after start; standby after ninth clock if select failed
	always_comb
	begin
		act_nxt  = act_r;
		sclk_nxt = sclk_r;
		if (start_ev)
		begin
			act_nxt  = 1'b1;
			sclk_nxt = 4'h0;
		end
		else if (stop_ev)
			act_nxt = 1'b0;
		else if (act_r && scl_rise && sclk_r < 4'(SEL_CLOCKS))
		begin
			sclk_nxt = sclk_r + 4'h1;
			if (sclk_r == 4'(SEL_CLOCKS - 1) && !sel_match)
				act_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev_r <= '{scl: 1'b1, sda: 1'b1};
			act_r  <= 1'b0;
			sclk_r <= 4'h0;
		end
		else
		begin
			prev_r <= filt;
			act_r  <= act_nxt;
			sclk_r <= sclk_nxt;
		end
	end

	// ------------------------------------------------------------
	// Restart pulse qualification
	// ------------------------------------------------------------
	localparam int unsigned RSP_CYC = RESTART_NS / CLK_PERIOD_NS;
	logic [8:0] rsp_r;
	logic [8:0] rsp_nxt;
	logic       restart_ok;

	// Count high time; a restart counts once the pulse reaches 1 us
	always_comb
	begin
		rsp_nxt = 9'h000;
		if (wdt_restart)
			rsp_nxt = (rsp_r == 9'(RSP_CYC)) ? rsp_r : rsp_r + 9'h001;
	end
	assign restart_ok = wdt_restart && rsp_r == 9'(RSP_CYC - 1);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rsp_r <= 9'h000;
		else
			rsp_r <= rsp_nxt;
	end

	// ------------------------------------------------------------
	// Power-on delay, watchdog interval and alarm time-out
	// ------------------------------------------------------------
	svwt_state_t    st_r;
	svwt_state_t    st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] por_lim;
	logic [CNT_W-1:0] wdt_lim;
	logic [CNT_W-1:0] rst_lim;
	logic [1:0]     por_cap_r;
	logic [1:0]     por_cap_nxt;

	// Catch the power-on selector once, in the first cycle after reset
	always_comb
	begin
		por_cap_nxt = por_cap_r;
		if (st_r == SVWT_POR && cnt_r == '0)
			por_cap_nxt = cfg.por_sel;
	end

	// Power-on delay limit from the selector caught after reset
	always_comb
	begin
		case (por_cap_r)
			2'h0:    por_lim = CNT_W'(POR_50_MS * CYC_MS);
			2'h1:    por_lim = CNT_W'(POR_200_MS * CYC_MS);
			2'h2:    por_lim = CNT_W'(POR_400_MS * CYC_MS);
			default: por_lim = CNT_W'(POR_800_MS * CYC_MS);
		endcase
	end

	// Interval and alarm hold limits from the interval selector
	always_comb
	begin
		case (cfg.wdt_sel)
			2'h0:    wdt_lim = CNT_W'(WDT_1400_MS * CYC_MS);
			2'h1:    wdt_lim = CNT_W'(WDT_200_MS * CYC_MS);
			default: wdt_lim = CNT_W'(WDT_25_MS * CYC_MS);
		endcase
		if (cfg.wdt_sel == WDT_SEL_SHORT)
			rst_lim = CNT_W'(RST_SHORT_MS * CYC_MS);
		else
			rst_lim = CNT_W'(RST_LONG_MS * CYC_MS);
	end

	// Sequence: power-on hold, watchdog run, alarm hold
	always_comb
	begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r + CNT_W'(1);
		case (st_r)
			SVWT_POR:
			begin
				if (cnt_r >= por_lim - CNT_W'(1))
				begin
					st_nxt  = SVWT_RUN;
					cnt_nxt = '0;
				end
			end
			SVWT_RUN:
			begin
				if (cfg.wdt_sel == WDT_SEL_OFF || restart_ok)
					cnt_nxt = '0;
				else if (cnt_r >= wdt_lim - CNT_W'(1))
				begin
					st_nxt  = SVWT_ALARM;
					cnt_nxt = '0;
				end
			end
			SVWT_ALARM:
			begin
				if (cnt_r >= rst_lim - CNT_W'(1))
				begin
					st_nxt  = SVWT_RUN;
					cnt_nxt = '0;
				end
			end
			default:
			begin
				st_nxt  = SVWT_POR;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r      <= SVWT_POR;
			cnt_r     <= '0;
			por_cap_r <= POR_SEL_RST;
		end
		else
		begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			por_cap_r <= por_cap_nxt;
		end
	end

	// ------------------------------------------------------------
	// Self-timed nonvolatile write cycle
	// ------------------------------------------------------------
	localparam longint unsigned WR_CYC = WRITE_CYCLE_MS * CYC_MS;
	svwt_wr_t         wr_r;
	svwt_wr_t         wr_nxt;
	logic [CNT_W-1:0] wcnt_r;
	logic [CNT_W-1:0] wcnt_nxt;

	// Start on a valid stop ending a write; end after the write time
	always_comb
	begin
		wr_nxt   = wr_r;
		wcnt_nxt = '0;
		case (wr_r)
			SVWT_IDLE:
				if (write_stop)
					wr_nxt = SVWT_BUSY;
			SVWT_BUSY:
			begin
				wcnt_nxt = wcnt_r + CNT_W'(1);
				if (wcnt_r >= CNT_W'(WR_CYC - 1))
				begin
					wr_nxt   = SVWT_IDLE;
					wcnt_nxt = '0;
				end
			end
			default:
				wr_nxt = SVWT_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_r   <= SVWT_IDLE;
			wcnt_r <= '0;
		end
		else
		begin
			wr_r   <= wr_nxt;
			wcnt_r <= wcnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reset_n          = (st_r != SVWT_POR);
	assign watchdog_alarm_n = (st_r != SVWT_ALARM);
	assign write_busy       = (wr_r == SVWT_BUSY);
	assign bus_active       = act_r | write_busy;

endmodule

// ==== hdl/svwt_pkg.sv ====
// Package of constants and types for the supervisor watchdog timing block
package svwt_pkg;

	// ------------------------------------------------------------
	// Clock rate and derived cycle counts
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 4;
	localparam int unsigned NS_PER_MS       = 1000000;

	// Power-on delay choices in ms
	localparam int unsigned POR_50_MS       = 50;
	localparam int unsigned POR_200_MS      = 200;
	localparam int unsigned POR_400_MS      = 400;
	localparam int unsigned POR_800_MS      = 800;

	// Watchdog intervals in ms (1.4 s written as 1400 ms)
	localparam int unsigned WDT_1400_MS     = 1400;
	localparam int unsigned WDT_200_MS      = 200;
	localparam int unsigned WDT_25_MS       = 25;

	// Watchdog reset time-out, typical, in ms
	localparam int unsigned RST_LONG_MS     = 200;
	localparam int unsigned RST_SHORT_MS    = 25;

	// Nonvolatile write cycle, typical, in ms (inside the 10 ms limit)
	localparam int unsigned WRITE_CYCLE_MS  = 5;

	// Glitch suppression time in ns
	localparam int unsigned GLITCH_NS       = 50;

	// Restart pulse least width in ns
	localparam int unsigned RESTART_NS      = 1000;

	// Bus clocks before standby after an unmatched select
	localparam int unsigned SEL_CLOCKS      = 9;

	// Cycle counts: least times round up
	localparam longint unsigned CYC_PER_MS  = NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values of the selectors (factory settings), and the off and short interval codes
	localparam logic [1:0] POR_SEL_RST      = 2'h1;
	localparam logic [1:0] WDT_SEL_RST      = 2'h3;
	localparam logic [1:0] WDT_SEL_OFF      = 2'h3;
	localparam logic [1:0] WDT_SEL_SHORT    = 2'h2;

	// Counter width, enough for 1400 ms at 250 MHz
	localparam int unsigned CNT_W           = 32;

	// Main state machine
	typedef enum logic [1:0]
	{
		SVWT_POR   = 2'b00,
		SVWT_RUN   = 2'b01,
		SVWT_ALARM = 2'b10
	} svwt_state_t;

	// Nonvolatile write sequencer state
	typedef enum logic [0:0]
	{
		SVWT_IDLE  = 1'b0,
		SVWT_BUSY  = 1'b1
	} svwt_wr_t;

	// Selector pair carried together
	typedef struct packed
	{
		logic [1:0] por_sel;
		logic [1:0] wdt_sel;
	} svwt_cfg_t;

	// Filtered bus line pair
	typedef struct packed
	{
		logic scl;
		logic sda;
	} svwt_bus_t;

endpackage

// ==== hdl/svwt_glitch_filter.sv ====
// Glitch filter that passes a level only after it is stable long enough
module svwt_glitch_filter
	import svwt_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic din,
	output logic      dout
);

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic       out_r;
	logic       out_nxt;

	// Count cycles the input differs from output; flip after the limit
	always_comb
	begin
		cnt_nxt = 8'h00;
		out_nxt = out_r;
		if (din != out_r)
		begin
			if (cnt_r >= 8'(GLITCH_CYC - 1))
				out_nxt = din;
			else
				cnt_nxt = cnt_r + 8'h01;
		end
	end

	// Registers, idle bus level high
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r <= 8'h00;
			out_r <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign dout = out_r;

endmodule

// ==== test/svwt_top_chk.sv ====
// Checker that ties the timing outputs to their causes
module svwt_top_chk
	import svwt_pkg::*;
#(
	parameter longint unsigned CYC_MS = CYC_PER_MS
)
(
	input wire logic                clk,
	input wire logic                arst_n,
	input wire svwt_pkg::svwt_cfg_t cfg,
	input wire logic                scl_in,
	input wire logic                sda_in,
	input wire logic                wdt_restart,
	input wire logic                write_stop,
	input wire logic                sel_match,
	input wire logic                reset_n,
	input wire logic                watchdog_alarm_n,
	input wire logic                write_busy,
	input wire logic                bus_active,
	input wire svwt_pkg::svwt_bus_t bus_filt
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int M = int'(CYC_MS);
	int por_c;
	int lo_c;
	int bsy_c;
	int run_c;
	int q_c;
	int lim;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Interval picked by the selector
	assign lim = (cfg.wdt_sel == 2'h0) ? 1400 * M : (cfg.wdt_sel == 2'h1) ? 200 * M : 25 * M;
	// Cycle counters; quiet time clears on a full restart or during an alarm
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			por_c <= 0;
			lo_c <= 0;
			bsy_c <= 0;
			run_c <= 0;
			q_c <= 0;
		end
		else
		begin
			por_c <= por_c + 1;
			lo_c <= watchdog_alarm_n ? 0 : lo_c + 1;
			bsy_c <= write_busy ? bsy_c + 1 : 0;
			run_c <= wdt_restart ? run_c + 1 : 0;
			q_c <= (!watchdog_alarm_n || (wdt_restart && run_c == 249)) ? 0 : q_c + 1;
		end
	end
	property p_por; $rose(reset_n) |-> por_c >= 50 * M - 2 && por_c <= 800 * M + 2; endproperty
	a_por: assert property (p_por) else $error("power-on delay");
	property p_off; $fell(watchdog_alarm_n) |-> cfg.wdt_sel != WDT_SEL_OFF; endproperty
	a_off: assert property (p_off) else $error("alarm while off");
	property p_quiet; $fell(watchdog_alarm_n) |-> q_c >= lim - 3; endproperty
	a_quiet: assert property (p_quiet) else $error("alarm too early");
	property p_hold_l; $rose(watchdog_alarm_n) && cfg.wdt_sel != WDT_SEL_SHORT
		|-> lo_c >= 100 * M && lo_c <= 300 * M; endproperty
	a_hold_l: assert property (p_hold_l) else $error("long alarm hold");
	property p_hold_s; $rose(watchdog_alarm_n) && cfg.wdt_sel == WDT_SEL_SHORT
		|-> lo_c * 2 >= 25 * M && lo_c * 2 <= 75 * M; endproperty
	a_hold_s: assert property (p_hold_s) else $error("short alarm hold");
	property p_wr_go; write_stop && !write_busy |=> write_busy; endproperty
	a_wr_go: assert property (p_wr_go) else $error("write not started");
	property p_wr_len; $fell(write_busy) |-> bsy_c >= 5 * M - 2 && bsy_c <= 10 * M; endproperty
	a_wr_len: assert property (p_wr_len) else $error("write length");
	property p_filt; $changed(bus_filt.scl) |-> $past(scl_in, 12) == bus_filt.scl; endproperty
	a_filt: assert property (p_filt) else $error("glitch passed");
	// A running write cycle keeps the device out of standby
	property p_act; write_busy |-> bus_active; endproperty
	a_act: assert property (p_act) else $error("busy but in standby");
endmodule

bind svwt_top svwt_top_chk #(.CYC_MS(CYC_MS)) u_chk
(
	.clk              (clk),
	.arst_n           (arst_n),
	.cfg              (cfg),
	.scl_in           (scl_in),
	.sda_in           (sda_in),
	.wdt_restart      (wdt_restart),
	.write_stop       (write_stop),
	.sel_match        (sel_match),
	.reset_n          (reset_n),
	.watchdog_alarm_n (watchdog_alarm_n),
	.write_busy       (write_busy),
	.bus_active       (bus_active),
	.bus_filt         (bus_filt)
);

// ==== test/svwt_host.sv ====
// Host model driving restarts, write stops and the bus lines
module svwt_host
(
	input  wire logic clk,
	output logic      rs,
	output logic      ws,
	output logic      scl,
	output logic      sda,
	output logic      sm
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: bus lines at their pull-up level
	initial
	begin
		{rs, ws, sm} = 3'h0;
		{scl, sda} = 2'h3;
	end
	// Restart held n cycles; 250 or more counts
	task automatic pulse(input int n);
		@(posedge clk) #1 rs = 1'h1;
		repeat (n) @(posedge clk);
		#1 rs = 1'h0;
	endtask
	// One-cycle stop ending a write
	task automatic stop();
		@(posedge clk) #1 ws = 1'h1;
		@(posedge clk) #1 ws = 1'h0;
	endtask
	// Clock line held at v for n cycles
	task automatic hold(input logic v, input int n);
		@(posedge clk) #1 scl = v;
		repeat (n) @(posedge clk);
	endtask
	// Start: data falls while the clock line is high
	task automatic start();
		@(posedge clk) #1 sda = 1'h1;
		hold(1'h1, 20);
		@(posedge clk) #1 sda = 1'h0;
		repeat (20) @(posedge clk);
		hold(1'h0, 20);
	endtask
	// Address select outcome seen at the ninth clock
	task automatic select(input logic v);
		@(posedge clk) #1 sm = v;
	endtask
	// Bus clocks of 20 cycles high and 20 low
	task automatic clocks(input int n);
		repeat (n)
		begin
			hold(1'h1, 20);
			hold(1'h0, 20);
		end
	endtask
endmodule

// ==== test/tb_supervisor_watchdog_timing.sv ====
// Self-checking testbench for the supervisor timing block
module tb_supervisor_watchdog_timing;
	import svwt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10;
	typedef struct
	{
		svwt_cfg_t c;
		int        por;
		int        wdt;
		int        hold;
	} svwt_row_t;
	svwt_row_t rows [4] = '{'{4'h2, 50, 25, 25}, '{4'h5, 200, 200, 200},
		'{4'hB, 400, 0, 0}, '{4'hC, 800, 1400, 200}};
	logic      clk;
	logic      arst_n;
	svwt_cfg_t cfg;
	logic      rs, ws, scl, sda, sm, rst_n, alm_n, busy, act;
	svwt_bus_t filt;
	int        n_mismatch = 0;
	int        tests_run = 0;
	int        n;
	always #2 clk = ~clk;
	svwt_host host (.clk(clk), .rs(rs), .ws(ws), .scl(scl), .sda(sda), .sm(sm));
	svwt_top #(.CYC_MS(MS)) uut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .scl_in(scl),
		.sda_in(sda), .wdt_restart(rs), .write_stop(ws), .sel_match(sm), .reset_n(rst_n),
		.watchdog_alarm_n(alm_n), .write_busy(busy), .bus_active(act), .bus_filt(filt));
	// Verdict and end of run
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic fail(input string m);
		n_mismatch++;
		$display("ERROR %0t %s", $time, m);
	endtask
	// Cycle counts may differ by two edges
	task automatic chk_cnt(input int got, input int exp);
		tests_run++;
		if (got < exp - 2 || got > exp + 2)
			fail($sformatf("count %0d not %0d", got, exp));
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
			fail("level");
	endtask
	// Edges until s shows v, bounded
	task automatic meas(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v && k < lim)
		begin
			@(posedge clk) #1;
			k++;
		end
		if (k >= lim)
		begin
			fail("timeout");
			complete_run();
		end
	endtask
	// Reset for six cycles with new selectors; outputs checked in reset
	task automatic rst_go(input svwt_cfg_t c);
		@(posedge clk) #1 arst_n = 1'h0;
		cfg = c;
		repeat (6) @(posedge clk);
		chk_bit({rst_n, alm_n, busy, act, filt} === 6'h13, 1'h1);
		#1 arst_n = 1'h1;
	endtask
	initial
	begin
		clk = 1'h0;
		arst_n = 1'h0;
		cfg = 4'h7;
		foreach (rows[i])
		begin
			rst_go(rows[i].c);
			meas(rst_n, 1'h1, 9000, n);
			chk_cnt(n, rows[i].por * MS);
			if (rows[i].wdt == 0)
			begin
				host.pulse(100);
				repeat (3000) @(posedge clk);
				chk_bit(alm_n, 1'h1);
			end
			else
			begin
				// A 1 us restart is as long as the shortest scaled interval
				if (rows[i].wdt > 25)
					host.pulse(250);
				meas(alm_n, 1'h0, 15000, n);
				chk_cnt(n, rows[i].wdt * MS);
				meas(alm_n, 1'h1, 3000, n);
				chk_cnt(n, rows[i].hold * MS);
			end
		end
		// Short restart ignored, full restart reloads the interval
		rst_go(4'h1);
		meas(rst_n, 1'h1, 900, n);
		host.pulse(250);
		repeat (20) @(posedge clk);
		host.pulse(200);
		meas(alm_n, 1'h0, 3000, n);
		// Interval less the 221 cycles spent since the full restart
		chk_cnt(n, WDT_200_MS * MS - 221);
		meas(alm_n, 1'h1, 3000, n);
		chk_cnt(n, RST_LONG_MS * MS);
		host.pulse(250);
		repeat (100) @(posedge clk);
		host.pulse(250);
		meas(alm_n, 1'h0, 3000, n);
		chk_cnt(n, WDT_200_MS * MS);
		// Write cycle; a stop while busy is ignored
		host.stop();
		chk_bit(busy, 1'h1);
		repeat (20) @(posedge clk);
		host.stop();
		meas(busy, 1'h0, 900, n);
		chk_cnt(n, WRITE_CYCLE_MS * MS - 21);
		repeat (10 * MS) @(posedge clk);
		// Programming voltage off time before a next cycle
		repeat (MS) @(posedge clk);
		// Twelve low samples (48 ns) blocked, sixteen pass
		host.hold(1'h0, 11);
		chk_bit(filt.scl, 1'h1);
		host.hold(1'h1, 20);
		chk_bit(filt.scl, 1'h1);
		host.hold(1'h0, 16);
		chk_bit(filt.scl, 1'h0);
		// Unmatched select ends activity on the ninth clock
		host.start();
		chk_bit(act, 1'h1);
		host.clocks(8);
		chk_bit(act, 1'h1);
		host.clocks(1);
		chk_bit(act, 1'h0);
		// Matched select keeps the bus active past the ninth clock
		host.select(1'h1);
		host.start();
		host.clocks(9);
		chk_bit(act, 1'h1);
		// Reset in mid-write; outputs at the second edge after release
		host.stop();
		rst_go(4'h7);
		repeat (2) @(posedge clk);
		#1 chk_bit({rst_n, alm_n, busy, act} === 4'h4, 1'h1);
		complete_run();
	end
endmodule
